// [hdl/plc_map.vh]
`ifndef PLC_MAP_VH
`define PLC_MAP_VH

// register byte offsets
`define PLC_OFS_SETTLE      8'h00
`define PLC_OFS_PUMP        8'h04
`define PLC_OFS_TUNE        8'h08
`define PLC_OFS_STATUS      8'h0c

// settle control fields
`define PLC_WIN_SEL_BIT     0
`define PLC_CNT_SEL_LSB     1
`define PLC_CNT_SEL_MSB     2
`define PLC_SETTLE_RST      3'h0

// pump control fields
`define PLC_CUR_LSB         0
`define PLC_CUR_MSB         2
`define PLC_SRC_BIT         3
`define PLC_SNK_BIT         4
`define PLC_HIZ_BIT         5
`define PLC_MID_BIT         6
`define PLC_WIDE_BIT        7
`define PLC_PUMP_RST        8'h00

// tuning control fields
`define PLC_DIV_LSB         0
`define PLC_DIV_MSB         3
`define PLC_RAO_BIT         4
`define PLC_START_BIT       5
`define PLC_POR_BIT         6
`define PLC_LPD_BIT         7
`define PLC_OPD_BIT         8
`define PLC_DIV_RST         4'h0
`define PLC_PD_RST          2'h0
`define PLC_DIV_MAX_CODE    4'hb

// status fields
`define PLC_ST_SETTLED      0
`define PLC_ST_SETTLED_N    1
`define PLC_ST_SLIP         2
`define PLC_ST_REF          3
`define PLC_ST_VALID        4
`define PLC_ST_BUSY         5
`define PLC_ST_DIV_BAD      6

// consecutive comparison counts per select code
`define PLC_COUNT_1         12'h020
`define PLC_COUNT_2         12'h100
`define PLC_COUNT_3         12'h800

// tuning cycle length in divided clocks
`define PLC_TUNE_TICKS      4'he

`endif

// [hdl/plc_top.v]
`timescale 1ns/1ps
`include "plc_map.vh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - window select picks narrow or wide window
// - settled only after enough consecutive in-window
// - count select: off, 32, 256, 2048
// - out-of-window: slip set, settled cleared at once
// - in-window comparison drops slip immediately
// - flags meaningful only with reference present
// - three-bit pump current magnitude select
// - force source or sink constant current
// - pump reset holds detector, pump high impedance
// - mid bias switches half-supply bias in
// - wide pulse lengthens detector reset delay
// - tuning stays valid until power-on reset or the next accepted start
// - tuning logic clocked by programmable divider
// - divider codes 0 to 11; 12-15 invalid
// - inverted settled flag always complement
// - start bit runs 14 ticks, self-clears
module plc_top #(
   parameter CNT_W = 12
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [7:0]    paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   input  wire          phase_cmp_strobe,
   input  wire          phase_in_window_narrow,
   input  wire          phase_in_window_wide,
   input  wire          ref_present,
   output reg           phase_settled,
   output wire          phase_settled_n,
   output reg           phase_slip,
   output reg           window_select,
   output reg  [2:0]    pump_current_select,
   output reg           pump_force_source,
   output reg           pump_force_sink,
   output reg           pump_reset_hiz,
   output wire          pfd_pulse_enable,
   output reg           pump_mid_bias,
   output reg           pump_wide_pulse,
   output reg           ref_aligned_feedback,
   output reg           loop_powerdown,
   output reg           oscillator_powerdown,
   output reg           tune_busy,
   output reg           tune_done,
   output reg           tune_valid
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   wire [3:0] pin_raw;
   reg  [3:0] sync1;
   reg  [3:0] sync2;
   reg        strobe_d;

   assign pin_raw = {ref_present, phase_in_window_wide, phase_in_window_narrow,
                     phase_cmp_strobe};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
            end else begin
               sync1[gi] <= pin_raw[gi];
               sync2[gi] <= sync1[gi];
            end
         end
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_d <= 1'b0;
      end else begin
         strobe_d <= sync2[0];
      end
   end

   wire cmp_event  = sync2[0] & ~strobe_d;
   wire ref_ok     = sync2[3];
   // window comparison is analog; logic only chooses which comparator counts
   wire in_window  = window_select ? sync2[2] : sync2[1];

   ////////////////////////////////////////////////////////////////////////////////
   // register bus

   wire wr_en   = psel & penable & pwrite;
   wire mapped  = (paddr == `PLC_OFS_SETTLE) || (paddr == `PLC_OFS_PUMP) ||
                  (paddr == `PLC_OFS_TUNE)   || (paddr == `PLC_OFS_STATUS);
   wire wr_set  = wr_en & (paddr == `PLC_OFS_SETTLE);
   wire wr_pump = wr_en & (paddr == `PLC_OFS_PUMP);
   wire wr_tune = wr_en & (paddr == `PLC_OFS_TUNE);
   wire sw_por  = wr_tune & pwdata[`PLC_POR_BIT];
   wire start_req = wr_tune & pwdata[`PLC_START_BIT] & ~sw_por;

   assign pready  = psel & penable;
   assign pslverr = psel & penable & ~mapped;

   reg  [1:0] settle_count_select;
   reg  [3:0] tuning_clock_divider_select;
   reg        tune_start;
   reg        div_invalid;
   reg        tune_state;

   reg [31:0] read_word;
   always @* begin
      read_word = 32'h0000_0000;
      case (paddr)
         `PLC_OFS_SETTLE: begin
            read_word[`PLC_WIN_SEL_BIT] = window_select;
            read_word[`PLC_CNT_SEL_MSB:`PLC_CNT_SEL_LSB] = settle_count_select;
         end
         `PLC_OFS_PUMP: begin
            read_word[`PLC_CUR_MSB:`PLC_CUR_LSB] = pump_current_select;
            read_word[`PLC_SRC_BIT]  = pump_force_source;
            read_word[`PLC_SNK_BIT]  = pump_force_sink;
            read_word[`PLC_HIZ_BIT]  = pump_reset_hiz;
            read_word[`PLC_MID_BIT]  = pump_mid_bias;
            read_word[`PLC_WIDE_BIT] = pump_wide_pulse;
         end
         `PLC_OFS_TUNE: begin
            read_word[`PLC_DIV_MSB:`PLC_DIV_LSB] = tuning_clock_divider_select;
            read_word[`PLC_RAO_BIT]   = ref_aligned_feedback;
            read_word[`PLC_START_BIT] = tune_start;
            read_word[`PLC_LPD_BIT]   = loop_powerdown;
            read_word[`PLC_OPD_BIT]   = oscillator_powerdown;
         end
         `PLC_OFS_STATUS: begin
            read_word[`PLC_ST_SETTLED]   = phase_settled;
            read_word[`PLC_ST_SETTLED_N] = phase_settled_n;
            read_word[`PLC_ST_SLIP]      = phase_slip;
            read_word[`PLC_ST_REF]       = ref_ok;
            read_word[`PLC_ST_VALID]     = tune_valid;
            read_word[`PLC_ST_BUSY]      = tune_busy;
            read_word[`PLC_ST_DIV_BAD]   = div_invalid;
         end
         default: read_word = 32'h0000_0000;
      endcase
   end

   // captured in setup so the word is steady through the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= read_word;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {settle_count_select, window_select} <= `PLC_SETTLE_RST;
         {pump_wide_pulse, pump_mid_bias, pump_reset_hiz, pump_force_sink,
          pump_force_source, pump_current_select} <= `PLC_PUMP_RST;
         tuning_clock_divider_select <= `PLC_DIV_RST;
         ref_aligned_feedback <= 1'b0;
         {oscillator_powerdown, loop_powerdown} <= `PLC_PD_RST;
      end else if (sw_por) begin
         {settle_count_select, window_select} <= `PLC_SETTLE_RST;
         {pump_wide_pulse, pump_mid_bias, pump_reset_hiz, pump_force_sink,
          pump_force_source, pump_current_select} <= `PLC_PUMP_RST;
         tuning_clock_divider_select <= `PLC_DIV_RST;
         ref_aligned_feedback <= 1'b0;
         {oscillator_powerdown, loop_powerdown} <= `PLC_PD_RST;
      end else begin
         if (wr_set) begin
            window_select       <= pwdata[`PLC_WIN_SEL_BIT];
            settle_count_select <= pwdata[`PLC_CNT_SEL_MSB:`PLC_CNT_SEL_LSB];
         end
         if (wr_pump) begin
            pump_current_select <= pwdata[`PLC_CUR_MSB:`PLC_CUR_LSB];
            pump_force_source   <= pwdata[`PLC_SRC_BIT];
            pump_force_sink     <= pwdata[`PLC_SNK_BIT];
            pump_reset_hiz      <= pwdata[`PLC_HIZ_BIT];
            pump_mid_bias       <= pwdata[`PLC_MID_BIT];
            pump_wide_pulse     <= pwdata[`PLC_WIDE_BIT];
         end
         // divider code is frozen while a tuning cycle runs
         if (wr_tune & (tune_state == ST_IDLE)) begin
            tuning_clock_divider_select <= pwdata[`PLC_DIV_MSB:`PLC_DIV_LSB];
         end
         if (wr_tune) begin
            ref_aligned_feedback <= pwdata[`PLC_RAO_BIT];
            loop_powerdown       <= pwdata[`PLC_LPD_BIT];
            oscillator_powerdown <= pwdata[`PLC_OPD_BIT];
         end
      end
   end

   // detector held in reset suppresses both pulse directions
   assign pfd_pulse_enable = ~pump_reset_hiz;

   ////////////////////////////////////////////////////////////////////////////////
   // phase settle qualifier

   function [CNT_W-1:0] settle_target;
      input [1:0] sel;
      begin
         case (sel)
            2'h1:    settle_target = `PLC_COUNT_1;
            2'h2:    settle_target = `PLC_COUNT_2;
            2'h3:    settle_target = `PLC_COUNT_3;
            default: settle_target = {CNT_W{1'b0}};
         endcase
      end
   endfunction

   reg  [CNT_W-1:0] run_count;
   wire [CNT_W-1:0] target_last = settle_target(settle_count_select) - 12'h001;

   // flags set only on comparisons, which need a running reference; count select 0 and software reset clear them
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_count     <= {CNT_W{1'b0}};
         phase_settled <= 1'b0;
         phase_slip    <= 1'b0;
      end else if (sw_por || settle_count_select == 2'h0) begin
         run_count     <= {CNT_W{1'b0}};
         phase_settled <= 1'b0;
         phase_slip    <= 1'b0;
      end else if (cmp_event) begin
         if (!in_window) begin
            run_count     <= {CNT_W{1'b0}};
            phase_slip    <= 1'b1;
            phase_settled <= 1'b0;
         end else begin
            phase_slip <= 1'b0;
            if (run_count == target_last) begin
               phase_settled <= 1'b1;
            end else begin
               run_count <= run_count + 12'h001;
            end
         end
      end
   end

   assign phase_settled_n = ~phase_settled;

   ////////////////////////////////////////////////////////////////////////////////
   // oscillator tuning sequencer

   wire       tune_tick;
   reg  [3:0] tick_count;
   wire       code_ok = (pwdata[`PLC_DIV_MSB:`PLC_DIV_LSB] <= `PLC_DIV_MAX_CODE);

   plc_tune_div #(
      .CW        (9)
   ) u_tune_div (
      .clk       (pclk),
      .rst_n     (presetn),
      .enable    (tune_state == ST_RUN),
      .event_in  (cmp_event),
      .ratio_sel (tuning_clock_divider_select),
      .tick      (tune_tick)
   );

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tune_state  <= ST_IDLE;
         tune_start  <= 1'b0;
         tick_count  <= 4'h0;
         tune_busy   <= 1'b0;
         tune_done   <= 1'b0;
         tune_valid  <= 1'b0;
         div_invalid <= 1'b0;
      end else if (sw_por) begin
         tune_state  <= ST_IDLE;
         tune_start  <= 1'b0;
         tick_count  <= 4'h0;
         tune_busy   <= 1'b0;
         tune_done   <= 1'b0;
         tune_valid  <= 1'b0;
         div_invalid <= 1'b0;
      end else begin
         tune_done <= 1'b0;
         case (tune_state)
            ST_IDLE: begin
               if (start_req) begin
                  if (code_ok) begin
                     tune_state  <= ST_RUN;
                     tune_start  <= 1'b1;
                     tune_busy   <= 1'b1;
                     tune_valid  <= 1'b0;
                     tick_count  <= 4'h0;
                     div_invalid <= 1'b0;
                  end else begin
                     div_invalid <= 1'b1;
                  end
               end
            end
            ST_RUN: begin
               if (tune_tick) begin
                  if (tick_count == `PLC_TUNE_TICKS - 4'h1) begin
                     tune_state <= ST_IDLE;
                     tune_start <= 1'b0;
                     tune_busy  <= 1'b0;
                     tune_done  <= 1'b1;
                     tune_valid <= 1'b1;
                  end else begin
                     tick_count <= tick_count + 4'h1;
                  end
               end
            end
            default: begin
               tune_state <= ST_IDLE;
               tune_start <= 1'b0;
               tune_busy  <= 1'b0;
            end
         endcase
      end
   end

endmodule

// [hdl/plc_tune_div.v]
`timescale 1ns/1ps
`include "plc_map.vh"

// divides comparison events down to the tuning logic clock tick
module plc_tune_div #(
   parameter CW = 9
) (
   input  wire          clk,
   input  wire          rst_n,
   input  wire          enable,
   input  wire          event_in,
   input  wire [3:0]    ratio_sel,
   output reg           tick
);

   reg  [CW-1:0] count;
   wire [CW-1:0] last;

   function [CW-1:0] ratio_of;
      input [3:0] sel;
      begin
         case (sel)
            4'h0:    ratio_of = 9'h008;
            4'h1:    ratio_of = 9'h00c;
            4'h2:    ratio_of = 9'h010;
            4'h3:    ratio_of = 9'h018;
            4'h4:    ratio_of = 9'h020;
            4'h5:    ratio_of = 9'h030;
            4'h6:    ratio_of = 9'h040;
            4'h7:    ratio_of = 9'h060;
            4'h8:    ratio_of = 9'h080;
            4'h9:    ratio_of = 9'h0c0;
            4'ha:    ratio_of = 9'h100;
            4'hb:    ratio_of = 9'h180;
            // invalid codes never run; start is refused upstream
            default: ratio_of = 9'h008;
         endcase
      end
   endfunction

   assign last = ratio_of(ratio_sel) - 9'h001;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= {CW{1'b0}};
         tick  <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (!enable) begin
            count <= {CW{1'b0}};
         end else if (event_in) begin
            if (count == last) begin
               count <= {CW{1'b0}};
               tick  <= 1'b1;
            end else begin
               count <= count + 9'h001;
            end
         end
      end
   end

endmodule

// [tb/plc_host.sv]
`timescale 1ns/1ps
// apb master standing in for the configuring host
module plc_host (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // waits for pready as long as it takes; a dead slave is left to the bench watchdog
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do begin
            @(posedge pclk);
         end while (pready !== 1'b1);
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
endmodule

// [tb/plc_top_properties.sv]
`timescale 1ns/1ps
`include "plc_map.vh"
module plc_top_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        phase_in_window_narrow,
   input wire logic        phase_in_window_wide,
   input wire logic        phase_settled,
   input wire logic        phase_settled_n,
   input wire logic        phase_slip,
   input wire logic        window_select,
   input wire logic [2:0]  pump_current_select,
   input wire logic        pump_force_source,
   input wire logic        pump_force_sink,
   input wire logic        pump_reset_hiz,
   input wire logic        pfd_pulse_enable,
   input wire logic        pump_mid_bias,
   input wire logic        pump_wide_pulse,
   input wire logic        tune_busy,
   input wire logic        tune_done,
   input wire logic        tune_valid
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_acc = psel && penable && pwrite;
   ////////////////////////////////////////////////////////////////////////////
   sequence s_tune_start;
      $rose(tune_busy);
   endsequence
   sequence s_tune_hold;
      tune_busy [*8];
   endsequence
   property p_tune_len;
      s_tune_start |-> s_tune_hold;
   endproperty
   a_tune_len: assert property (p_tune_len)
      else $error("tuning ended too early");
   property p_tune_done;
      tune_done |-> tune_valid && !tune_busy && $past(tune_busy);
   endproperty
   a_tune_done: assert property (p_tune_done)
      else $error("tuning completion pulse out of place");
   property p_settled_inv;
      phase_settled_n == !phase_settled;
   endproperty
   a_settled_inv: assert property (p_settled_inv)
      else $error("inverted settled flag not complement");
   property p_hiz;
      pfd_pulse_enable == !pump_reset_hiz;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("detector pulses not held by pump reset");
   property p_slip_excl;
      phase_slip |-> !phase_settled;
   endproperty
   a_slip_excl: assert property (p_slip_excl)
      else $error("settled while slipping");
   property p_settle_win;
      $rose(phase_settled) |->
         (window_select ? $past(phase_in_window_wide, 3) : $past(phase_in_window_narrow, 3));
   endproperty
   a_settle_win: assert property (p_settle_win)
      else $error("settled set on out-of-window comparison");
   property p_slip_win;
      $rose(phase_slip) |->
         !(window_select ? $past(phase_in_window_wide, 3) : $past(phase_in_window_narrow, 3));
   endproperty
   a_slip_win: assert property (p_slip_win)
      else $error("slip set on in-window comparison");
   property p_pump_wr;
      wr_acc && paddr == `PLC_OFS_PUMP |=> {pump_wide_pulse, pump_mid_bias, pump_reset_hiz,
         pump_force_sink, pump_force_source, pump_current_select} == $past(pwdata[7:0]);
   endproperty
   a_pump_wr: assert property (p_pump_wr)
      else $error("pump controls differ from written value");
   property p_win_wr;
      wr_acc && paddr == `PLC_OFS_SETTLE |=> window_select == $past(pwdata[0]);
   endproperty
   a_win_wr: assert property (p_win_wr)
      else $error("window select differs from written value");
   property p_valid_kept;
      tune_valid && !(psel && pwrite && paddr == `PLC_OFS_TUNE) |=> tune_valid;
   endproperty
   a_valid_kept: assert property (p_valid_kept)
      else $error("tuning result lost without reset");
   property p_div_bad;
      wr_acc && paddr == `PLC_OFS_TUNE && pwdata[5] && !pwdata[6] && !tune_busy
         && pwdata[3:0] > `PLC_DIV_MAX_CODE |=> !tune_busy;
   endproperty
   a_div_bad: assert property (p_div_bad)
      else $error("tuning started with invalid divider code");
endmodule
bind plc_top plc_top_properties u_plc_top_properties (.*);

// [tb/plc_top_tb.sv]
`timescale 1ns/1ps
`include "plc_map.vh"
module plc_top_tb;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] r;
      logic        e;
   } plc_row;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        phase_cmp_strobe, phase_in_window_narrow, phase_in_window_wide, ref_present;
   logic        phase_settled, phase_settled_n, phase_slip, window_select, pfd_pulse_enable;
   logic [2:0]  pump_current_select;
   logic        pump_force_source, pump_force_sink, pump_reset_hiz, pump_mid_bias;
   logic        pump_wide_pulse, ref_aligned_feedback, loop_powerdown, oscillator_powerdown;
   logic        tune_busy, tune_done, tune_valid;
   int          miscompares = 0;
   int          samples_checked = 0;
   int          n;
   int          done_seen = 0;
   int          cnt [4] = '{0, 32, 256, 2048};
   plc_row      rows [13] = '{
      '{8'h00, 32'hffffffff, 32'h7, 1'b0}, '{8'h04, 32'h08, 32'h08, 1'b0},
      '{8'h04, 32'h11, 32'h11, 1'b0}, '{8'h04, 32'h22, 32'h22, 1'b0},
      '{8'h04, 32'h43, 32'h43, 1'b0}, '{8'h04, 32'h84, 32'h84, 1'b0},
      '{8'h04, 32'h25, 32'h25, 1'b0}, '{8'h04, 32'h06, 32'h06, 1'b0},
      '{8'h04, 32'hff, 32'hff, 1'b0}, '{8'h08, 32'h190, 32'h190, 1'b0},
      '{8'h10, 32'h5, 32'h0, 1'b1}, '{8'h04, 32'h0, 32'h0, 1'b0},
      '{8'h08, 32'h0, 32'h0, 1'b0}};
   plc_top  u_plc_top (.*);
   plc_host u_plc_host (.*);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task conclude;
      begin
         if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      begin
         samples_checked++;
         if (g !== x) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
         end
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      u_plc_host.xfer(1'b1, a, d, r, e);
   endtask
   task rd(input logic [7:0] a);
      u_plc_host.xfer(1'b0, a, 32'h0, r, e);
   endtask
   // windows held steady well around the strobe edge for the synchronizers
   task cmp(input logic nw, input logic ww);
      begin
         phase_in_window_narrow <= nw;
         phase_in_window_wide <= ww;
         repeat (3) @(posedge pclk);
         phase_cmp_strobe <= 1'b1;
         repeat (3) @(posedge pclk);
         phase_cmp_strobe <= 1'b0;
         repeat (3) @(posedge pclk);
      end
   endtask
   // the completion pulse stands one cycle, so it is counted where it stands
   always @(posedge pclk) begin
      if (tune_done === 1'b1) done_seen++;
   end
   initial begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      phase_cmp_strobe = 1'b0;
      phase_in_window_narrow = 1'b0;
      phase_in_window_wide = 1'b0;
      ref_present = 1'b1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      chk(phase_settled_n, 1'b1);
      chk(pfd_pulse_enable, 1'b1);
      for (int k = 0; k < 13; k++) begin
         wr(rows[k].a, rows[k].d);
         chk(e, rows[k].e);
         rd(rows[k].a);
         chk(e, rows[k].e);
         chk(r, rows[k].r);
         if (rows[k].a == `PLC_OFS_PUMP) begin
            chk({pump_wide_pulse, pump_mid_bias, pump_reset_hiz, pump_force_sink,
                 pump_force_source, pump_current_select}, rows[k].d[7:0]);
            chk(pfd_pulse_enable, !rows[k].d[5]);
         end
         if (rows[k].a == `PLC_OFS_SETTLE) chk(window_select, rows[k].d[0]);
         if (rows[k].a == `PLC_OFS_TUNE)
            chk({oscillator_powerdown, loop_powerdown, ref_aligned_feedback},
                {rows[k].d[8], rows[k].d[7], rows[k].d[4]});
      end
      // pump and bias bits already cleared by the last rows
      wr(`PLC_OFS_SETTLE, 32'h0);
      cmp(1'b0, 1'b0);
      chk(phase_slip, 1'b0);
      for (int s = 1; s < 4; s++) begin
         wr(`PLC_OFS_SETTLE, s << 1); // narrow window for a fast detector
         cmp(1'b0, 1'b0);
         chk(phase_slip, 1'b1);
         for (int i = 1; i < cnt[s]; i++) cmp(1'b1, 1'b0);
         chk(phase_settled, 1'b0);
         cmp(1'b1, 1'b0);
         chk(phase_settled, 1'b1);
         rd(`PLC_OFS_STATUS);
         chk(r[3:0], 4'h9);
         cmp(1'b0, 1'b1);
         chk({phase_settled, phase_slip}, 2'h1);
         cmp(1'b1, 1'b1);
         chk({phase_settled, phase_slip}, 2'h0);
      end
      wr(`PLC_OFS_SETTLE, 32'h3);
      cmp(1'b0, 1'b1);
      chk(phase_slip, 1'b0);
      wr(`PLC_OFS_TUNE, 32'h2c);
      rd(`PLC_OFS_STATUS);
      chk(r[6:5], 2'h2);
      // settling wait and band choice are the host's part
      wr(`PLC_OFS_TUNE, 32'h20);
      rd(`PLC_OFS_TUNE);
      chk(r[5], 1'b1);
      n = 0;
      while (tune_busy === 1'b1 && n < 400) begin
         cmp(1'b1, 1'b1);
         n++;
      end
      chk(n, 112);
      chk(done_seen, 1);
      rd(`PLC_OFS_TUNE);
      chk({r[5], tune_valid}, 2'h1);
      wr(`PLC_OFS_PUMP, 32'h3f);
      chk(tune_valid, 1'b1);
      wr(`PLC_OFS_TUNE, 32'h40);
      @(negedge pclk);
      chk({tune_valid, pump_current_select, pump_reset_hiz}, 5'h0);
      // reset again in mid-run, right on the edge that lands a write
      wr(`PLC_OFS_SETTLE, 32'h1);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({window_select, phase_settled_n, tune_busy}, 3'h2);
      rd(`PLC_OFS_SETTLE);
      chk(r, 32'h0);
      conclude();
   end
endmodule
